// ---- src/rsb_alu_pkg.sv ----
// Constants, register map and types of the rotate / subtract-with-borrow
// datapath. Assumes a single 200 MHz core clock and an AXI4-Lite host.
package rsb_alu_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int BYTE_W    = 8;
    localparam int BUS_AW    = 8;
    localparam int BUS_DW    = 32;
    localparam int MEM_AW    = 8;
    localparam int MEM_DEPTH = 256;
    localparam int OP_W      = 3;
    localparam int FLAGS_W   = 6;
    localparam int STATE_W   = 3;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [BUS_AW-1:0] CMD_OFS    = 8'h00;
    localparam logic [BUS_AW-1:0] ACC_OFS    = 8'h04;
    localparam logic [BUS_AW-1:0] FLAGS_OFS  = 8'h08;
    localparam logic [BUS_AW-1:0] STATUS_OFS = 8'h0c;
    localparam logic [BUS_AW-1:0] MADDR_OFS  = 8'h10;
    localparam logic [BUS_AW-1:0] MDATA_OFS  = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int FLAG_C       = 0;
    localparam int FLAG_AC      = 1;
    localparam int FLAG_Z       = 2;
    localparam int FLAG_OV      = 3;
    localparam int FLAG_SC      = 4;
    localparam int FLAG_CZ      = 5;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_ERR     = 1;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [BYTE_W-1:0]  ACC_RST   = 8'h00;
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 6'h00;
    localparam logic [BYTE_W-1:0]  MADDR_RST = 8'h00;
    localparam logic [BUS_DW-1:0]  CMD_RST   = 32'h0000_0000;

    // ************************************************************
    // Operation codes
    // ************************************************************
    localparam logic [OP_W-1:0] OP_ROT_RIGHT_TO_ACC         = 3'h0;
    localparam logic [OP_W-1:0] OP_ROT_RIGHT_THRU_CARRY_MEM = 3'h1;
    localparam logic [OP_W-1:0] OP_ROT_RIGHT_THRU_CARRY_ACC = 3'h2;
    localparam logic [OP_W-1:0] OP_SUB_BORROW_TO_ACC        = 3'h3;
    localparam logic [OP_W-1:0] OP_SUB_BORROW_TO_MEM        = 3'h4;

    // ************************************************************
    // Bus responses and engine states
    // ************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [STATE_W-1:0] {
        ST_IDLE  = 3'h1,
        ST_FETCH = 3'h2,
        ST_EXEC  = 3'h4
    } eng_state_type;

endpackage

// ---- src/byte_store.sv ----
// Byte-wide data memory with a single port and registered read data.
// Assumes one access per cycle; the owner arbitrates between users.
`timescale 1ns/100ps
module byte_store
    import rsb_alu_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Access port
    input  wire logic                en,
    input  wire logic                we,
    input  wire logic [MEM_AW-1:0]   addr,
    input  wire logic [BYTE_W-1:0]   wdata,
    output logic      [BYTE_W-1:0]   rdata
);

    logic [BYTE_W-1:0] mem_reg [MEM_DEPTH];
    logic [BYTE_W-1:0] rdata_reg;
    logic [BYTE_W-1:0] rdata_next;

    assign rdata = rdata_reg;

    always_comb
    begin
        rdata_next = rdata_reg;
        if (en && !we)
        begin
            rdata_next = mem_reg[addr];
        end
    end

    // Array has no reset: contents are data, not control state
    always_ff @(posedge aclk)
    begin
        if (en && we)
        begin
            mem_reg[addr] <= wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

endmodule

// ---- src/rotate_subtract_borrow_alu.sv ----
// Rotate-right and subtract-with-borrow datapath with its accumulator,
// status flags and data memory, controlled over AXI4-Lite.
// Assumes the host follows AXI4-Lite handshakes; one clock, sync reset.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module rotate_subtract_borrow_alu
    import rsb_alu_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Write address channel
    input  wire logic [BUS_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // Write data channel
    input  wire logic [BUS_DW-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // Write response channel
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // Read address channel
    input  wire logic [BUS_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // Read data channel
    output logic [BUS_DW-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                 aw_held_reg,  aw_held_next;
    logic [BUS_AW-1:0]    awaddr_reg,   awaddr_next;
    logic                 w_held_reg,   w_held_next;
    logic [BUS_DW-1:0]    wdata_reg,    wdata_next;
    logic [3:0]           wstrb_reg,    wstrb_next;
    logic                 bvalid_reg,   bvalid_next;
    logic [1:0]           bresp_reg,    bresp_next;
    logic                 rvalid_reg,   rvalid_next;
    logic [1:0]           rresp_reg,    rresp_next;
    logic [BUS_DW-1:0]    rdata_reg,    rdata_next;
    logic                 rd_pend_reg,  rd_pend_next;

    eng_state_type        state_reg,    state_next;
    logic [BUS_DW-1:0]    cmd_reg,      cmd_next;
    logic [BYTE_W-1:0]    acc_reg,      acc_next;
    logic [FLAGS_W-1:0]   flags_reg,    flags_next;
    logic [BYTE_W-1:0]    maddr_reg,    maddr_next;
    logic                 err_reg,      err_next;

    logic                 eng_idle;
    logic                 do_write;
    logic                 do_read;
    logic                 wr_mapped;
    logic                 rd_mapped;
    logic [BUS_DW-1:0]    wr_merged;
    logic [BUS_DW-1:0]    rd_value;
    logic [OP_W-1:0]      op;
    logic [MEM_AW-1:0]    op_addr;

    logic                 mem_en;
    logic                 mem_we;
    logic [MEM_AW-1:0]    mem_addr;
    logic [BYTE_W-1:0]    mem_wdata;
    logic [BYTE_W-1:0]    mem_rdata;

    logic                 carry_in;
    logic                 borrow_in;
    logic [BYTE_W:0]      diff9;
    logic [4:0]           diff_lo;
    logic [BYTE_W-1:0]    diff;
    logic                 sub_ov;
    logic                 sub_z;
    logic [FLAGS_W-1:0]   sub_flags;

    // Merge write data into the old word, lane by lane
    function automatic logic [BUS_DW-1:0] merge_strb(
        input logic [BUS_DW-1:0] old_word,
        input logic [BUS_DW-1:0] new_word,
        input logic [3:0]        strb
    );
        logic [BUS_DW-1:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // Bus handshakes
    // ************************************************************
    assign eng_idle = (state_reg == ST_IDLE);
    // Registers change only while the engine rests, so software never
    // races an instruction that is half done
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg && eng_idle;
    // A read waits behind a pending write: the memory has one port
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg && !rd_pend_reg && eng_idle
                           && !(aw_held_reg && w_held_reg);
    assign do_read  = s_axi_arvalid && s_axi_arready;

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    assign wr_mapped = (awaddr_reg == CMD_OFS)   ||
                       (awaddr_reg == ACC_OFS)   ||
                       (awaddr_reg == FLAGS_OFS) ||
                       (awaddr_reg == MADDR_OFS) ||
                       (awaddr_reg == MDATA_OFS);
    assign rd_mapped = wr_mapped_rd(s_axi_araddr);

    function automatic logic wr_mapped_rd(input logic [BUS_AW-1:0] a);
        return (a == CMD_OFS) || (a == ACC_OFS) || (a == FLAGS_OFS) ||
               (a == STATUS_OFS) || (a == MADDR_OFS) || (a == MDATA_OFS);
    endfunction

    always_comb
    begin
        rd_value = '0;
        unique case (s_axi_araddr)
            CMD_OFS:    rd_value = cmd_reg;
            ACC_OFS:    rd_value[BYTE_W-1:0] = acc_reg;
            FLAGS_OFS:  rd_value[FLAGS_W-1:0] = flags_reg;
            STATUS_OFS:
            begin
                rd_value[STAT_BUSY] = !eng_idle;
                rd_value[STAT_ERR]  = err_reg;
            end
            MADDR_OFS:  rd_value[BYTE_W-1:0] = maddr_reg;
            default:    rd_value = '0;
        endcase
    end

    always_comb
    begin
        aw_held_next = aw_held_reg;
        awaddr_next  = awaddr_reg;
        w_held_next  = w_held_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        rd_pend_next = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (do_read)
        begin
            rresp_next = rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_next = rd_value;
            if (s_axi_araddr == MDATA_OFS)
            begin
                // Memory read data come one cycle later
                rd_pend_next = 1'b1;
            end
            else
            begin
                rvalid_next = 1'b1;
            end
        end
        else if (rd_pend_reg)
        begin
            rvalid_next = 1'b1;
            rdata_next  = {{(BUS_DW-BYTE_W){1'b0}}, mem_rdata};
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_held_reg  <= 1'b0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= '0;
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            awaddr_reg  <= awaddr_next;
            w_held_reg  <= w_held_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            rd_pend_reg <= rd_pend_next;
        end
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    assign op        = cmd_reg[CMD_OP_LSB +: OP_W];
    assign op_addr   = cmd_reg[CMD_ADDR_LSB +: MEM_AW];
    assign carry_in  = flags_reg[FLAG_C];
    assign borrow_in = !carry_in;
    // Accumulator minus memory minus inverted carry, ninth bit = borrow
    assign diff9   = {1'b0, acc_reg} - {1'b0, mem_rdata}
                     - {{BYTE_W{1'b0}}, borrow_in};
    assign diff_lo = {1'b0, acc_reg[3:0]} - {1'b0, mem_rdata[3:0]}
                     - {4'h0, borrow_in};
    assign diff    = diff9[BYTE_W-1:0];
    assign sub_ov  = (acc_reg[7] ^ mem_rdata[7]) & (acc_reg[7] ^ diff[7]);
    assign sub_z   = (diff == 8'h00);

    always_comb
    begin
        sub_flags          = flags_reg;
        sub_flags[FLAG_C]  = !diff9[BYTE_W];
        sub_flags[FLAG_AC] = !diff_lo[4];
        sub_flags[FLAG_Z]  = sub_z;
        sub_flags[FLAG_OV] = sub_ov;
        sub_flags[FLAG_SC] = sub_ov ^ diff[7];
        // Chained zero holds only while every chained byte was zero
        sub_flags[FLAG_CZ] = sub_z & flags_reg[FLAG_CZ];
    end

    // ************************************************************
    // Memory port: engine while busy, software while idle
    // ************************************************************
    always_comb
    begin
        mem_en    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = maddr_reg;
        mem_wdata = wdata_reg[BYTE_W-1:0];
        unique case (state_reg)
            ST_IDLE:
            begin
                if (do_write && awaddr_reg == MDATA_OFS && wstrb_reg[0])
                begin
                    mem_en = 1'b1;
                    mem_we = 1'b1;
                end
                else if (do_read && s_axi_araddr == MDATA_OFS)
                begin
                    mem_en = 1'b1;
                end
            end
            ST_FETCH:
            begin
                mem_en   = 1'b1;
                mem_addr = op_addr;
            end
            ST_EXEC:
            begin
                mem_addr = op_addr;
                if (op == OP_ROT_RIGHT_THRU_CARRY_MEM)
                begin
                    mem_en    = 1'b1;
                    mem_we    = 1'b1;
                    mem_wdata = {carry_in, mem_rdata[7:1]};
                end
                else if (op == OP_SUB_BORROW_TO_MEM)
                begin
                    mem_en    = 1'b1;
                    mem_we    = 1'b1;
                    mem_wdata = diff;
                end
            end
        endcase
    end

    byte_store u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (mem_en),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    // ************************************************************
    // Engine and architectural registers
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        acc_next   = acc_reg;
        flags_next = flags_reg;
        maddr_next = maddr_reg;
        err_next   = err_reg;
        wr_merged  = '0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (do_write)
                begin
                    unique case (awaddr_reg)
                        CMD_OFS:
                        begin
                            wr_merged = merge_strb(cmd_reg, wdata_reg,
                                                   wstrb_reg);
                            cmd_next  = wr_merged;
                            // Unknown codes are stored in cmd_reg but not run, and flagged
                            if (wr_merged[CMD_OP_LSB +: OP_W]
                                > OP_SUB_BORROW_TO_MEM)
                            begin
                                err_next = 1'b1;
                            end
                            else
                            begin
                                err_next   = 1'b0;
                                state_next = ST_FETCH;
                            end
                        end
                        ACC_OFS:
                        begin
                            if (wstrb_reg[0])
                            begin
                                acc_next = wdata_reg[BYTE_W-1:0];
                            end
                        end
                        FLAGS_OFS:
                        begin
                            if (wstrb_reg[0])
                            begin
                                flags_next = wdata_reg[FLAGS_W-1:0];
                            end
                        end
                        MADDR_OFS:
                        begin
                            if (wstrb_reg[0])
                            begin
                                maddr_next = wdata_reg[BYTE_W-1:0];
                            end
                        end
                        default:
                        begin
                            acc_next = acc_reg;
                        end
                    endcase
                end
            end
            ST_FETCH:
            begin
                state_next = ST_EXEC;
            end
            ST_EXEC:
            begin
                state_next = ST_IDLE;
                unique case (op)
                    OP_ROT_RIGHT_TO_ACC:
                    begin
                        acc_next = {mem_rdata[0], mem_rdata[7:1]};
                    end
                    OP_ROT_RIGHT_THRU_CARRY_MEM:
                    begin
                        flags_next[FLAG_C] = mem_rdata[0];
                    end
                    OP_ROT_RIGHT_THRU_CARRY_ACC:
                    begin
                        acc_next = {carry_in, mem_rdata[7:1]};
                        flags_next[FLAG_C] = mem_rdata[0];
                    end
                    OP_SUB_BORROW_TO_ACC:
                    begin
                        acc_next   = diff;
                        flags_next = sub_flags;
                    end
                    OP_SUB_BORROW_TO_MEM:
                    begin
                        flags_next = sub_flags;
                    end
                    default:
                    begin
                        acc_next = acc_reg;
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            cmd_reg   <= CMD_RST;
            acc_reg   <= ACC_RST;
            flags_reg <= FLAGS_RST;
            maddr_reg <= MADDR_RST;
            err_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            acc_reg   <= acc_next;
            flags_reg <= flags_next;
            maddr_reg <= maddr_next;
            err_reg   <= err_next;
        end
    end

endmodule

// ---- verif/rsb_alu_asserts.sv ----
// Checker on the bus ports of the rotate / subtract-with-borrow block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rsb_alu_asserts
    import rsb_alu_pkg::*;
(
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [BUS_AW-1:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [BUS_DW-1:0] s_axi_wdata, s_axi_rdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("no write answer");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("no read answer");
    chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h18 |=> s_axi_rvalid
        && s_axi_rresp == RESP_SLVERR) else $error("unmapped read ok");
    chk_b_blocks: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("ready in b");
    chk_r_single: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid repeated");
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind rotate_subtract_borrow_alu rsb_alu_asserts u_chk (.*);

// ---- verif/rsb_host_model.sv ----
// AXI4-Lite master standing in for the decoder side of the block.
// Assumes the slave answers; the bench watchdog bounds any hang.
`timescale 1ns/100ps
module rsb_host_model
(
    input  wire logic        aclk,
    output logic [7:0]       awaddr, araddr,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             awvalid, wvalid, bready, arvalid, rready,
    input  wire logic        awready, wready, bvalid, arready, rvalid,
    input  wire logic [1:0]  bresp, rresp,
    input  wire logic [31:0] rdata
);
    initial
    begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hf;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        // Each channel lets go at its own handshake edge
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule

// ---- verif/rotate_subtract_borrow_alu_tb.sv ----
// Bench: runs every operation through the register bus and checks
// accumulator, flags and memory against a reference worked out here.
`timescale 1ns/100ps
module rotate_subtract_borrow_alu_tb
    import rsb_alu_pkg::*;
;
    logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd_;
    logic [3:0] ws;
    logic [1:0] bre, rre, resp;
    logic [31:0] v;
    int errors, n_tests;
    logic [7:0] a_t [10] = '{8'h00,8'h00,8'h00,8'h50,8'h50,
                             8'h00,8'h00,8'h00,8'h00,8'h80};
    logic [7:0] m_t [10] = '{8'h81,8'h81,8'h02,8'h50,8'h50,
                             8'h7f,8'h01,8'h80,8'h01,8'h10};
    logic [5:0] f_t [10] = '{6'h3f,6'h00,6'h21,6'h20,6'h21,
                             6'h00,6'h3e,6'h01,6'h01,6'h01};
    rotate_subtract_borrow_alu DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rre),
        .s_axi_rvalid(rv), .s_axi_rready(rr));
    rsb_host_model host (.aclk(aclk), .awaddr(awa), .araddr(ara),
        .wdata(wd), .wstrb(ws), .awvalid(awv), .wvalid(wv), .bready(br),
        .arvalid(arv), .rready(rr), .awready(awr), .wready(wr_),
        .bvalid(bv), .arready(arr), .rvalid(rv), .bresp(bre),
        .rresp(rre), .rdata(rd_));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Runs one operation and compares all three destinations
    task automatic run(int i);
        logic [2:0] op;
        logic [7:0] a, m, ea, em, r;
        logic [5:0] f, ef;
        logic [8:0] d;
        logic [4:0] h;
        op = 3'(i % 5);
        {a, m, f} = {a_t[i], m_t[i], f_t[i]};
        {ea, em, ef} = {a, m, f};
        d = {1'b0, a} - m - !f[FLAG_C];
        h = {1'b0, a[3:0]} - m[3:0] - !f[FLAG_C];
        r = d[7:0];
        case (op)
            OP_ROT_RIGHT_TO_ACC: ea = {m[0], m[7:1]};
            OP_ROT_RIGHT_THRU_CARRY_MEM: em = {f[FLAG_C], m[7:1]};
            OP_ROT_RIGHT_THRU_CARRY_ACC: ea = {f[FLAG_C], m[7:1]};
            OP_SUB_BORROW_TO_ACC: ea = r;
            default: em = r;
        endcase
        if (op == OP_ROT_RIGHT_THRU_CARRY_MEM
            || op == OP_ROT_RIGHT_THRU_CARRY_ACC) ef[FLAG_C] = m[0];
        if (op >= OP_SUB_BORROW_TO_ACC)
        begin
            ef[FLAG_C] = !d[8];
            ef[FLAG_AC] = !h[4];
            ef[FLAG_Z] = (r == 8'h00);
            ef[FLAG_OV] = (a[7] ^ m[7]) & (a[7] ^ r[7]);
            ef[FLAG_SC] = ef[FLAG_OV] ^ r[7];
            ef[FLAG_CZ] = ef[FLAG_Z] & f[FLAG_CZ];
        end
        host.wr(MADDR_OFS, 32'(8'h20 + i), resp);
        host.wr(MDATA_OFS, {24'h0, m}, resp);
        host.wr(ACC_OFS, {24'h0, a}, resp);
        host.wr(FLAGS_OFS, {26'h0, f}, resp);
        host.wr(CMD_OFS, {16'h0, 8'h20 + 8'(i), 5'h0, op}, resp);
        host.rd(ACC_OFS, v, resp);
        chk("acc", v, {24'h0, ea});
        host.rd(FLAGS_OFS, v, resp);
        chk("flags", v, {26'h0, ef});
        host.rd(MDATA_OFS, v, resp);
        chk("mem", v, {24'h0, em});
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        wrap_up();
    end
    initial
    begin
        {errors, n_tests} = '0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        host.rd(ACC_OFS, v, resp);
        chk("acc reset", v, 32'h0);
        host.rd(FLAGS_OFS, v, resp);
        chk("flags reset", v, 32'h0);
        for (int i = 0; i < 10; i++) run(i);
        host.wr(CMD_OFS, 32'h0000_2005, resp);
        chk("bad op resp", 32'(resp), 32'(RESP_OKAY));
        host.rd(STATUS_OFS, v, resp);
        chk("status err", v, 32'h2);
        host.rd(CMD_OFS, v, resp);
        chk("cmd", v, 32'h0000_2005);
        host.rd(MADDR_OFS, v, resp);
        chk("maddr", v, 32'h29);
        host.wr(CMD_OFS, 32'h0000_2000, resp);
        host.rd(STATUS_OFS, v, resp);
        chk("status clr", v, 32'h0);
        host.wr(STATUS_OFS, 32'h3, resp);
        chk("status wr", 32'(resp), 32'(RESP_SLVERR));
        host.rd(8'h18, v, resp);
        chk("unmapped rd", 32'(resp), 32'(RESP_SLVERR));
        wrap_up();
    end
endmodule
